// ---- ssr_pkg.sv ----
// constants, states and config carrier for the sync-pin role and fault block
package ssr_pkg;

  // timing in ns, with cycle counts derived at the 125 MHz core clock
  localparam int         CLK_NS        = 8;
  localparam int         FSW_NS        = 64;     // free-running switching period
  localparam int         DET_NS        = 2000;   // power-up qualification window
  localparam int         LOSS_NS       = 10000;  // clock-loss detection latency
  localparam logic [3:0] FREE_CYC      = 4'(FSW_NS / CLK_NS);
  // 40 % lower frequency means a period of 1/0.6 times free-running
  localparam logic [3:0] SLOW_CYC      = 4'((FSW_NS * 10) / (CLK_NS * 6));
  localparam logic [3:0] HALF_CYC      = 4'(FSW_NS / (2 * CLK_NS));
  localparam logic [8:0] DET_CYC       = 9'(DET_NS / CLK_NS);
  localparam logic [10:0] LOSS_CYC     = 11'(LOSS_NS / CLK_NS);
  // a gap of two nominal periods exceeds the slowest legal external clock
  localparam logic [4:0] GAP_CYC       = 5'((2 * FSW_NS) / CLK_NS);
  localparam logic [2:0] RESTART_EDGES = 3'h7;
  localparam logic [2:0] DET_MIN_EDGES = 3'h3;
  // synchroniser fill time after reset; edges seen before it are not real
  localparam logic [8:0] PRIME_CYC     = 9'h003;

  typedef enum logic [2:0] {
    ST_DETECT = 3'h0,
    ST_WAIT   = 3'h1,
    ST_RUN    = 3'h2,
    ST_LOST   = 3'h3,
    ST_STOP   = 3'h4,
    ST_FREE   = 3'h5
  } ssr_state_t;

  typedef struct packed {
    logic force_in;     // stored override: pin is clock input
    logic force_out;    // stored override: pin is clock output
    logic loop_slave;   // device is the loop slave of a stack
    logic loss_dis;     // clock_loss_response_disable
  } ssr_cfg_t;

endpackage

// ---- ssr_sync_ctrl.sv ----
// sync-pin role detection, clock output, edge alignment and clock-loss handling
// What the document requires
// RULE1: clock or pullup at powerup selects input role
// RULE2: no edges at powerup: drive free-running clock out
// RULE3: clock master output has 50 percent duty
// RULE4: loop slave always input, aligned to falling edge; the code lets force-output make it an output
// RULE5: external clock within twenty percent of free-running
// RULE6: external clock to stack has 50 percent duty
// RULE7: decided role holds until power cycle
// RULE8: override bits beat detection; force-input wins
// RULE9: both override bits clear by default
// RULE10: no external clock while output is forced
// RULE11: stop switching when expected clock missing
// RULE12: live unlatched sync fault status, no alert
// RULE13: loss detected in 10 us, slave runs slow
// RULE14: never-present clock keeps device idle
// RULE15: seven edges after return, then new soft-start
// RULE16: loss-disable: no fault, slow 10 us, free-run
// RULE17: qualify powerup edges over a fixed window
`timescale 1ns/1ps
`default_nettype none

module ssr_sync_ctrl (
  input  wire logic            CLK,        // core clock, 125 MHz
  input  wire logic            RESETN,     // input-supply power-on reset
  input  wire ssr_pkg::ssr_cfg_t CFG,      // stored overrides and strap
  input  wire logic            SYNC_I,     // sync pin level in
  output logic                 SYNC_O,     // sync pin drive value
  output logic                 SYNC_OE,    // sync pin output enable
  output logic                 SW_PULSE,   // start of a switching cycle
  output logic                 SWITCHING,  // converter is switching
  output logic                 SYNC_FAULT, // live sync fault status
  output logic                 ROLE_IN,    // pin role is clock input
  output logic                 ROLE_DONE,  // role has been decided
  output logic                 SOFT_START  // request a new soft-start
);

  // ----------------------------------------------------------------
  // pin synchroniser and edge detect
  // ----------------------------------------------------------------
  logic s1_r, s2_r, s3_r;

  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
    end
    else
    begin
      s1_r <= SYNC_I;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  wire rise_w     = s2_r & ~s3_r;
  wire fall_w     = ~s2_r & s3_r;
  // stacked slave takes the falling edge so the phases interleave
  wire act_edge_w = CFG.loop_slave ? fall_w : rise_w;  // RULE1 RULE4

  // ----------------------------------------------------------------
  // state, counters and decode
  // ----------------------------------------------------------------
  ssr_pkg::ssr_state_t st_r, st_nxt;
  logic [8:0]  det_r;
  logic [2:0]  dedge_r;
  logic        role_in_r;
  logic [4:0]  gap_r;
  logic [10:0] tmr_r;
  logic [2:0]  rec_r;
  logic [3:0]  ph_r, ph_nxt;

  wire det_done_w = (st_r == ssr_pkg::ST_DETECT) && (det_r == ssr_pkg::DET_CYC - 9'h001);
  // pulled-up pin: high at the end of the window with no edges seen
  wire auto_in_w  = (dedge_r >= ssr_pkg::DET_MIN_EDGES)
                  | (s2_r & (dedge_r == 3'h0));                 // RULE1 RULE2 RULE17
  wire pick_in_w  = CFG.force_in
                  | (~CFG.force_out & (CFG.loop_slave | auto_in_w));  // RULE8 RULE9 RULE4
  wire lost_w     = role_in_r && (gap_r == ssr_pkg::GAP_CYC);    // RULE13
  wire tmr_done_w = tmr_r == ssr_pkg::LOSS_CYC - 11'h001;
  wire counting_w = (st_r == ssr_pkg::ST_WAIT) || (st_r == ssr_pkg::ST_STOP)
                  || (st_r == ssr_pkg::ST_FREE);
  wire rec_done_w = counting_w && act_edge_w
                  && (rec_r == ssr_pkg::RESTART_EDGES - 3'h1);   // RULE15
  wire own_time_w = ((st_r == ssr_pkg::ST_RUN) && !role_in_r)
                  || (st_r == ssr_pkg::ST_LOST) || (st_r == ssr_pkg::ST_FREE);
  wire [3:0] per_w = (st_r == ssr_pkg::ST_LOST) ? ssr_pkg::SLOW_CYC
                                                : ssr_pkg::FREE_CYC;  // RULE13 RULE16
  wire ph_wrap_w  = ph_r == per_w - 4'h1;
  wire sw_nxt_w   = own_time_w ? ph_wrap_w
                  : ((st_r == ssr_pkg::ST_RUN) && act_edge_w);   // RULE1 RULE4
  wire run_nxt_w  = (st_nxt == ssr_pkg::ST_RUN) || (st_nxt == ssr_pkg::ST_LOST)
                  || (st_nxt == ssr_pkg::ST_FREE);
  // a return from free-running never shut down, so no new soft-start
  wire ss_nxt_w   = (st_nxt == ssr_pkg::ST_RUN) && (st_r != ssr_pkg::ST_RUN)
                  && (st_r != ssr_pkg::ST_LOST) && (st_r != ssr_pkg::ST_FREE);  // RULE15
  wire flt_nxt_w  = ~CFG.loss_dis && ((st_nxt == ssr_pkg::ST_WAIT)
                  || (st_nxt == ssr_pkg::ST_STOP));              // RULE12 RULE16
  wire role_nxt_w = det_done_w ? pick_in_w : role_in_r;
  wire so_nxt_w   = ~role_nxt_w && (st_nxt == ssr_pkg::ST_RUN)
                  && (ph_nxt < ssr_pkg::HALF_CYC);               // RULE2 RULE3

  always_comb
  begin
    st_nxt = st_r;
    case (st_r)
      ssr_pkg::ST_DETECT: if (det_done_w) st_nxt = pick_in_w ? ssr_pkg::ST_WAIT
                                                            : ssr_pkg::ST_RUN;  // RULE2
      ssr_pkg::ST_WAIT:   if (rec_done_w) st_nxt = ssr_pkg::ST_RUN;        // RULE14
      ssr_pkg::ST_RUN:    if (lost_w) st_nxt = ssr_pkg::ST_LOST;           // RULE13
      ssr_pkg::ST_LOST:
        if (act_edge_w)
          st_nxt = ssr_pkg::ST_RUN;
        else if (tmr_done_w)
          st_nxt = CFG.loss_dis ? ssr_pkg::ST_FREE : ssr_pkg::ST_STOP;    // RULE11 RULE16
      ssr_pkg::ST_STOP:   if (rec_done_w) st_nxt = ssr_pkg::ST_RUN;        // RULE15
      ssr_pkg::ST_FREE:   if (rec_done_w) st_nxt = ssr_pkg::ST_RUN;
      default:            st_nxt = ssr_pkg::ST_DETECT;
    endcase
  end

  always_comb
  begin
    if (own_time_w && (st_nxt != ssr_pkg::ST_RUN || !role_nxt_w))
      ph_nxt = (ph_wrap_w || st_nxt != st_r) ? 4'h0 : ph_r + 4'h1;
    else if (st_nxt == ssr_pkg::ST_RUN && !role_nxt_w)
      ph_nxt = (st_r == ssr_pkg::ST_RUN) ? ph_r : 4'h0;
    else
      ph_nxt = 4'h0;
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      st_r      <= ssr_pkg::ST_DETECT;
      det_r     <= 9'h000;
      dedge_r   <= 3'h0;
      role_in_r <= 1'b0;
      gap_r     <= 5'h00;
      tmr_r     <= 11'h000;
      rec_r     <= 3'h0;
      ph_r      <= 4'h0;
    end
    else
    begin
      st_r      <= st_nxt;
      role_in_r <= role_nxt_w;                                   // RULE7
      det_r     <= (st_r == ssr_pkg::ST_DETECT) ? det_r + 9'h001 : det_r;
      // the synchroniser leaves reset low, so a pulled-up pin would fake one edge
      if ((st_r == ssr_pkg::ST_DETECT) && (rise_w | fall_w) && (dedge_r != 3'h7)
          && (det_r >= ssr_pkg::PRIME_CYC))
        dedge_r <= dedge_r + 3'h1;                               // RULE17 RULE1
      gap_r <= (act_edge_w || st_r != ssr_pkg::ST_RUN) ? 5'h00
             : (lost_w ? gap_r : gap_r + 5'h01);
      tmr_r <= (st_r == ssr_pkg::ST_LOST) ? tmr_r + 11'h001 : 11'h000;
      rec_r <= !counting_w ? 3'h0 : (act_edge_w ? rec_r + 3'h1 : rec_r);
      ph_r  <= ph_nxt;
    end
  end

  // every output straight from a flip-flop
  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      SYNC_O     <= 1'b0;
      SYNC_OE    <= 1'b0;
      SW_PULSE   <= 1'b0;
      SWITCHING  <= 1'b0;
      SYNC_FAULT <= 1'b0;
      ROLE_IN    <= 1'b0;
      ROLE_DONE  <= 1'b0;
      SOFT_START <= 1'b0;
    end
    else
    begin
      SYNC_O     <= so_nxt_w;
      SYNC_OE    <= ~role_nxt_w && (st_nxt != ssr_pkg::ST_DETECT);  // RULE10
      SW_PULSE   <= sw_nxt_w;
      SWITCHING  <= run_nxt_w;                                   // RULE11 RULE14
      SYNC_FAULT <= flt_nxt_w;                                   // RULE12
      ROLE_IN    <= role_nxt_w;
      ROLE_DONE  <= st_nxt != ssr_pkg::ST_DETECT;
      SOFT_START <= ss_nxt_w;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  // cycles spent in the loss state, kept apart from the state timer
  logic [11:0] loss_age_r;

  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
      loss_age_r <= 12'h000;
    else
      loss_age_r <= (st_r == ssr_pkg::ST_LOST) ? loss_age_r + 12'h001 : 12'h000;
  end

  role_fixed_a: assert property (@(posedge CLK) disable iff (!RESETN) // RULE7
    ROLE_DONE |=> ROLE_DONE && $stable(ROLE_IN))
    else $error("role changed after decision");
  force_in_a: assert property (@(posedge CLK) disable iff (!RESETN) // RULE8
    $rose(ROLE_DONE) && CFG.force_in |-> ROLE_IN)
    else $error("force-input override ignored");
  force_out_a: assert property (@(posedge CLK) disable iff (!RESETN) // RULE8
    $rose(ROLE_DONE) && CFG.force_out && !CFG.force_in |-> !ROLE_IN && SYNC_OE)
    else $error("force-output override ignored");
  slave_in_a: assert property (@(posedge CLK) disable iff (!RESETN) // RULE4
    $rose(ROLE_DONE) && CFG.loop_slave && !CFG.force_out |-> ROLE_IN)
    else $error("loop slave not in clock-input role");
  duty_half_a: assert property (@(posedge CLK) disable iff (!RESETN) // RULE3
    $rose(SYNC_O) && SYNC_OE |=> SYNC_O [*3] ##1 !SYNC_O [*4])
    else $error("clock output not 50 percent");
  fault_idle_a: assert property (@(posedge CLK) disable iff (!RESETN) // RULE11
    SYNC_FAULT |-> !SWITCHING && !SW_PULSE)
    else $error("switching while sync fault");
  fault_dis_a: assert property (@(posedge CLK) disable iff (!RESETN) // RULE16
    CFG.loss_dis && $stable(CFG.loss_dis) |=> !SYNC_FAULT)
    else $error("fault reported while disabled");
  loss_time_a: assert property (@(posedge CLK) disable iff (!RESETN) // RULE13
    (st_r == ssr_pkg::ST_LOST) |-> (loss_age_r < {1'b0, ssr_pkg::LOSS_CYC}))
    else $error("loss detection too slow");
  restart_a: assert property (@(posedge CLK) disable iff (!RESETN) // RULE15
    $rose(SOFT_START) |-> $past(counting_w, 2) || ($past(st_r, 2) == ssr_pkg::ST_DETECT))
    else $error("soft-start without clock return");

endmodule

`default_nettype wire

// ---- ssr_clk_src.sv ----
// far-side clock source model for the sync pin
`timescale 1ns/1ps
`default_nettype none
module ssr_clk_src (
  input  wire logic en,   // run the clock
  input  wire logic idle, // pulled level while quiet
  output logic      pin   // level on the sync pin
);
  logic tick = 1'b0;
  assign pin = en ? tick : idle;
  initial
  begin
    #3;
    forever #32 tick = en & ~tick;
  end
endmodule
`default_nettype wire

// ---- ssr_sync_ctrl_bench.sv ----
// self-checking bench for the sync-pin role and fault controller
`timescale 1ns/1ps
`default_nettype none
module ssr_sync_ctrl_bench;
  logic              clk = 1'b0, resetn = 1'b0, src_en = 1'b0, src_idle = 1'b0;
  logic              align_on = 1'b0, src_pin, sync_w, prev, sync_o, sync_oe, sw_pulse;
  logic              switching, sync_fault, role_in, role_done, soft_start;
  ssr_pkg::ssr_cfg_t cfg = '0;
  logic [31:0]       lfsr = 32'hF57D;
  int                error_cnt, check_count, cyc, since_rise, since_fall, n;
  // the source never drives while the design enables its driver, so no contention
  assign sync_w = sync_oe ? sync_o : src_pin;
  ssr_clk_src u_src (.en(src_en), .idle(src_idle), .pin(src_pin));
  ssr_sync_ctrl u_dut (.CLK(clk), .RESETN(resetn), .CFG(cfg), .SYNC_I(sync_w),
    .SYNC_O(sync_o), .SYNC_OE(sync_oe), .SW_PULSE(sw_pulse), .SWITCHING(switching),
    .SYNC_FAULT(sync_fault), .ROLE_IN(role_in), .ROLE_DONE(role_done), .SOFT_START(soft_start));
  initial
    forever #4 clk = ~clk;
  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function automatic logic [31:0] exp_quiet(input ssr_pkg::ssr_cfg_t c, input logic idle);
    logic r = c.force_in | (~c.force_out & (c.loop_slave | idle));
    return {29'h0, r, ~r, r & ~c.loss_dis};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    error_cnt += int'(got !== exp);
    if (got !== exp)
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
  endtask
  task automatic wait_for(ref logic s, input logic v, input int lim);
    for (n = 0; s !== v && n < lim; n++)
      @(negedge clk);
  endtask
  task automatic gap(input logic [31:0] exp);
    wait_for(sw_pulse, 1'b1, 40);
    @(negedge clk);
    wait_for(sw_pulse, 1'b1, 40);
    chk(32'(n + 1), exp);
  endtask
  task automatic boot(input logic [3:0] c, input logic run, input logic idle);
    resetn = 1'b0;
    cfg = ssr_pkg::ssr_cfg_t'(c);
    src_idle = idle;
    src_en = run;
    lfsr = lfsr_next(lfsr);
    repeat (2) @(negedge clk);
    resetn = 1'b1;
    wait_for(role_done, 1'b1, 400);
    chk(32'(role_done && n > 200), 32'h1);
  endtask
  task automatic complete_run();
    $display("checks=%0d mismatches=%0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    prev <= sync_w;
    since_rise <= (sync_w && !prev) ? 0 : since_rise + 1;
    since_fall <= (!sync_w && prev) ? 0 : since_fall + 1;
    if (align_on && sw_pulse === 1'b1)
      chk(32'((cfg.loop_slave ? since_fall : since_rise) inside {[2:5]}), 32'h1);
    if (cyc == 20000)
      error_cnt++;
    if (cyc == 20000)
      complete_run();
  end
  initial
  begin
    for (int d = 0; d < 3; d++)
    begin
      boot(4'(d), 1'b1, 1'b0);
      chk(32'({role_in, sync_fault}), d == 1 ? 32'h2 : 32'h3);
      wait_for(soft_start, 1'b1, 200);
      chk(32'({soft_start, switching, sync_fault}), 32'h6);
      align_on = 1'b1;
      repeat (40) @(negedge clk);
      align_on = 1'b0;
      src_en = 1'b0;
      repeat (40) @(negedge clk);
      gap(32'(ssr_pkg::SLOW_CYC));
      repeat (1300) @(negedge clk);
      chk(32'({switching, sync_fault, role_in}), d == 1 ? 32'h5 : 32'h3);
      if (d == 1) gap(32'(ssr_pkg::FREE_CYC));
      src_en = 1'b1;
      wait_for(soft_start, 1'b1, 120);
      chk(32'({soft_start, switching, sync_fault}), d == 1 ? 32'h2 : 32'h6);
      $display("test clocked cfg=%h done", cfg);
    end
    boot(4'h0, 1'b0, 1'b0);
    wait_for(sync_o, 1'b0, 20);
    wait_for(sync_o, 1'b1, 20);
    wait_for(sync_o, 1'b0, 20);
    chk(32'(n), 32'(ssr_pkg::HALF_CYC));
    chk(32'({role_in, sync_oe, switching}), 32'h3);
    gap(32'(ssr_pkg::FREE_CYC));
    $display("test clock out done");
    // corner cases first: both overrides set, then a plain pulled-up pin
    for (int i = 0; i < 7; i++)
    begin
      boot(i == 0 ? 4'hC : (i == 1 ? 4'h0 : lfsr[7:4]), 1'b0, i == 1 ? 1'b1 : lfsr[8]);
      repeat (20) @(negedge clk);
      chk(32'({role_in, switching, sync_fault}), exp_quiet(cfg, src_idle));
      $display("test quiet cfg=%h done", cfg);
    end
    complete_run();
  end
endmodule
`default_nettype wire
